// file: bench/power_interlock_model.sv
`timescale 1ns/1ns
module power_interlock_model (
	input  wire logic mclk,
	input  wire logic alarmOutput,
	input  wire logic powerRequest,
	output logic      mainPowerOn
);
	// The contactor opens one cycle after an alarm, so ready must fall from both causes.
	initial mainPowerOn = 1'b0;
	always @(posedge mclk) mainPowerOn <= #1 powerRequest & alarmOutput;
endmodule

// file: bench/servo_status_outputs_monitor.sv
`timescale 1ns/1ns
module servo_status_outputs_monitor (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [7:0]  faultDetect,
	input wire logic [7:0]  stickyMask,
	input wire logic        alarmClearInput,
	input wire logic        panelClearKey,
	input wire logic        mainPowerOn,
	input wire logic [11:0] motorSpeed,
	input wire logic [11:0] rotationSpeedThreshold,
	input wire logic        alarmOutput,
	input wire logic        rotationDetectOutput,
	input wire logic        servoReady,
	input wire logic [7:0]  latchedFaults
);
	wire fast = motorSpeed > (rotationSpeedThreshold > 12'hbb8 ? 12'hbb8 : rotationSpeedThreshold);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_fault_drops_alarm: assert property (|faultDetect |=> !alarmOutput && !servoReady)
		else $error("alarm or ready held on fault");
	a_sticky_keeps_alarm: assert property (|(latchedFaults & stickyMask) |=> !alarmOutput)
		else $error("sticky fault released");
	a_rotation_above: assert property (fast |=> rotationDetectOutput)
		else $error("rotation detect missing");
	a_rotation_below: assert property (!fast |=> !rotationDetectOutput)
		else $error("rotation detect spurious");
	a_ready_needs_alarm: assert property (servoReady |-> alarmOutput)
		else $error("ready during alarm");
	a_ready_needs_power: assert property (!mainPowerOn [*4] |-> !servoReady)
		else $error("ready without power");
	a_clear_input_acts: assert property ($rose(alarmClearInput) ##1
		(alarmClearInput && !faultDetect) [*2] |=> !(latchedFaults & ~stickyMask))
		else $error("clear input ignored");
	a_panel_key_acts: assert property ($rose(panelClearKey) ##1
		(panelClearKey && !faultDetect) [*2] |=> !(latchedFaults & ~stickyMask))
		else $error("panel key ignored");
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n |-> !alarmOutput && !servoReady)
		else $error("output active in reset");
endmodule
bind servo_status_outputs servo_status_outputs_monitor MON (.mclk(mclk), .rst_n(rst_n),
	.faultDetect(faultDetect), .stickyMask(stickyMask), .alarmClearInput(alarmClearInput),
	.panelClearKey(panelClearKey), .mainPowerOn(mainPowerOn), .motorSpeed(motorSpeed),
	.rotationSpeedThreshold(rotationSpeedThreshold), .alarmOutput(alarmOutput),
	.rotationDetectOutput(rotationDetectOutput), .servoReady(servoReady),
	.latchedFaults(latchedFaults));

// file: bench/servo_status_outputs_test.sv
`timescale 1ns/1ns
module servo_status_outputs_test;
	logic        mclk = 0, rst_n = 1, aClr = 0, key = 0, pReq = 1, pOn, aOut, rot, rdy;
	logic [7:0]  flt = 8'h00, lf;
	logic [7:0]  mask = servo_status_pkg::STICKY_MASK_DEFAULT;
	logic [11:0] spd = 0, thr = servo_status_pkg::THRESHOLD_DEFAULT;
	int          n_fail = 0, check_count = 0, i;
	servo_status_outputs DUT (.mclk(mclk), .rst_n(rst_n), .faultDetect(flt), .stickyMask(mask),
		.alarmClearInput(aClr), .panelClearKey(key), .mainPowerOn(pOn), .motorSpeed(spd),
		.rotationSpeedThreshold(thr), .alarmOutput(aOut), .rotationDetectOutput(rot),
		.servoReady(rdy), .latchedFaults(lf));
	power_interlock_model PWR (.mclk(mclk), .alarmOutput(aOut), .powerRequest(pReq),
		.mainPowerOn(pOn));
	initial forever #20 mclk = ~mclk;
	task tick(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task chk(logic seen, logic want);
		check_count++;
		if (seen !== want) begin
			n_fail++;
			$display("wrong value at %0t: got %b want %b", $time, seen, want);
		end
	endtask
	function logic det(logic [11:0] s, logic [11:0] t);
		return s > (t > servo_status_pkg::THRESHOLD_MAX ? servo_status_pkg::THRESHOLD_MAX : t);
	endfunction
	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		wrap_up;
	end
	initial begin
		void'($urandom(21));
		// A real falling edge on reset, so the design is cleared before the first clock.
		#1;
		rst_n = 0;
		tick(20);
		chk(aOut | rot | rdy, 1'b0);
		$display("reset test done");
		rst_n = 1;
		tick(8);
		chk(rdy, 1'b1);
		for (i = 0; i < 44; i++) begin
			thr = i < 2 ? 12'h014 : (i < 4 ? 12'hfff : 12'($urandom));
			spd = i < 4 ? thr - 12'h00e + 12'(i) : 12'($urandom);
			// Equal speed and threshold, and the clamp edge, are the likely slips.
			spd = i < 2 ? 12'h014 + 12'(i) : (i < 4 ? 12'hbb6 + 12'(i) : spd);
			tick(1);
			chk(rot, det(spd, thr));
		end
		$display("rotation test done");
		pReq = 0;
		tick(5);
		chk(rdy, 1'b0);
		pReq = 1;
		tick(5);
		chk(rdy, 1'b1);
		$display("power test done");
		for (i = 0; i < 8; i++) begin
			flt = 8'h01 << i;
			tick(1);
			flt = 8'h00;
			chk(aOut | rdy, 1'b0);
			chk(lf == (8'h01 << i), 1'b1);
			if (i[0]) aClr = 1;
			else key = 1;
			tick(3);
			chk(aOut, ~mask[i]);
			aClr = 0;
			key = 0;
			tick(6);
			chk(rdy, ~mask[i]);
			rst_n = 0;
			tick(2);
			rst_n = 1;
			tick(8);
			chk(aOut, 1'b1);
		end
		$display("fault test done");
		// A fault standing as reset ends must keep the alarm output OFF.
		flt = 8'h02;
		rst_n = 0;
		tick(2);
		rst_n = 1;
		tick(1);
		chk(aOut, 1'b0);
		flt = 8'h00;
		aClr = 1;
		tick(3);
		chk(aOut, 1'b1);
		aClr = 0;
		$display("reset fault test done");
		wrap_up;
	end
endmodule

// file: core/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinSync
);

	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_type;

	sync_state_type state;
	sync_state_type next_state;

	always_comb begin
		next_state.first = pinIn;
		next_state.second = state.first;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign pinSync = state.second;

endmodule

// file: core/servo_status_outputs.sv
`timescale 1ns/1ns
module servo_status_outputs (
	input  wire logic                                    mclk,
	input  wire logic                                    rst_n,
	input  wire logic [servo_status_pkg::FAULT_W-1:0]   faultDetect,
	input  wire logic [servo_status_pkg::FAULT_W-1:0]   stickyMask,
	input  wire logic                                    alarmClearInput,
	input  wire logic                                    panelClearKey,
	input  wire logic                                    mainPowerOn,
	input  wire logic [servo_status_pkg::SPEED_W-1:0]   motorSpeed,
	input  wire logic [servo_status_pkg::SPEED_W-1:0]   rotationSpeedThreshold,
	output logic                                         alarmOutput,
	output logic                                         rotationDetectOutput,
	output logic                                         servoReady,
	output logic      [servo_status_pkg::FAULT_W-1:0]   latchedFaults
);

	// All block state except the two pin_sync flop stages lives in one record; the edge detectors keep the
	// synchronised pin levels of the previous cycle in it.
	typedef struct packed {
		servo_status_pkg::alarm_state_type      mode;
		logic [servo_status_pkg::FAULT_W-1:0]   faults;
		logic [servo_status_pkg::SYNC_W-1:0]    pinPrev;
		servo_status_pkg::status_type           status;
	} block_state_type;

	block_state_type state;
	block_state_type next_state;

	logic [servo_status_pkg::SYNC_W-1:0] pinRaw;
	logic [servo_status_pkg::SYNC_W-1:0] pinNow;
	logic                                clearReq;
	logic [servo_status_pkg::SPEED_W-1:0] limit;

	// Threshold values beyond the documented range are clamped to the top.
	function automatic logic [servo_status_pkg::SPEED_W-1:0] clampSpeed(
		input logic [servo_status_pkg::SPEED_W-1:0] value
	);
		clampSpeed = (value > servo_status_pkg::THRESHOLD_MAX) ?
			servo_status_pkg::THRESHOLD_MAX : value;
	endfunction

	// Bit order of the synchronised bundle: clear input, panel key, main power.
	assign pinRaw = {mainPowerOn, panelClearKey, alarmClearInput};

	// Clear, key and power come from outside this clock, so each passes two flops.
	// The cost is two cycles of latency on every one of them.
	pin_sync #(
		.WIDTH (servo_status_pkg::SYNC_W)
	) pinSyncInst (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.pinIn   (pinRaw),
		.pinSync (pinNow)
	);

	// Each clear source has its own edge detector: a level held high clears only
	// once, so a stuck button or wire cannot hide a fault that arrives later.
	function automatic logic risingEdge(
		input logic levelNow,
		input logic levelBefore
	);
		risingEdge = levelNow & ~levelBefore;
	endfunction

	// Set wins over clear: a fault reported while a clear is taken stays latched,
	// since dropping it would hide a live alarm. Sticky classes ignore every clear.
	function automatic logic [servo_status_pkg::FAULT_W-1:0] mergeFaults(
		input logic [servo_status_pkg::FAULT_W-1:0] held,
		input logic [servo_status_pkg::FAULT_W-1:0] detect,
		input logic [servo_status_pkg::FAULT_W-1:0] keep,
		input logic                                 clear
	);
		logic [servo_status_pkg::FAULT_W-1:0] merged;
		merged = '0;
		for (int k = 0; k < servo_status_pkg::FAULT_W; k++) begin
			if (detect[k]) begin
				merged[k] = 1'b1;
			end else if (clear && !keep[k]) begin
				merged[k] = 1'b0;
			end else begin
				merged[k] = held[k];
			end
		end
		mergeFaults = merged;
	endfunction

	// The mode follows the fault set that is about to be stored, so the alarm
	// output and the latched faults always change on the same edge.
	function automatic servo_status_pkg::alarm_state_type stepMode(
		input servo_status_pkg::alarm_state_type current,
		input logic                              faultAhead
	);
		unique case (current)
			servo_status_pkg::ALM_RESET: begin
				// A fault present as reset ends must not flash the output ON for a cycle.
				if (faultAhead) begin
					stepMode = servo_status_pkg::ALM_FAULTED;
				end else begin
					stepMode = servo_status_pkg::ALM_RUN;
				end
			end
			servo_status_pkg::ALM_RUN: begin
				// Any class, new or held, drops the output on this same edge.
				if (faultAhead) begin
					stepMode = servo_status_pkg::ALM_FAULTED;
				end else begin
					stepMode = servo_status_pkg::ALM_RUN;
				end
			end
			servo_status_pkg::ALM_FAULTED: begin
				// Leaving needs every class gone, sticky ones included.
				if (faultAhead) begin
					stepMode = servo_status_pkg::ALM_FAULTED;
				end else begin
					stepMode = servo_status_pkg::ALM_RUN;
				end
			end
			default: begin
				// An illegal code falls back to reset so the outputs restart clean.
				stepMode = servo_status_pkg::ALM_RESET;
			end
		endcase
	endfunction

	// Only the run mode counts as healthy; reset and faulted both read as alarm.
	function automatic logic isRunning(
		input servo_status_pkg::alarm_state_type mode
	);
		isRunning = (mode == servo_status_pkg::ALM_RUN);
	endfunction

	// Equal speed and threshold reads OFF: motion is claimed only above the limit.
	// No hysteresis is added, so a speed hovering at the threshold makes the
	// output toggle; the speed input is expected to be filtered already.
	function automatic logic aboveLimit(
		input logic [servo_status_pkg::SPEED_W-1:0] speed,
		input logic [servo_status_pkg::SPEED_W-1:0] bound
	);
		aboveLimit = (speed > bound);
	endfunction

	// Ready needs both the synchronised power level and a fault-free mode.
	function automatic servo_status_pkg::status_type buildStatus(
		input logic running,
		input logic moving,
		input logic powered
	);
		servo_status_pkg::status_type result;
		result.alarmOutput = running;
		result.rotationDetectOutput = moving;
		result.servoReady = powered & running;
		buildStatus = result;
	endfunction

	// Names ending in Ahead carry what the coming clock edge will store, so the
	// outputs are formed from the same values that the state takes.
	logic                                 clearInputEdge;
	logic                                 panelKeyEdge;
	logic                                 powerPresent;
	logic [servo_status_pkg::FAULT_W-1:0] faultsAhead;
	logic                                 anyFaultAhead;
	servo_status_pkg::alarm_state_type    modeAhead;
	logic                                 runningAhead;
	logic                                 speedAbove;

	assign clearInputEdge = risingEdge(pinNow[0], state.pinPrev[0]);
	assign panelKeyEdge = risingEdge(pinNow[1], state.pinPrev[1]);
	// Key and clear input are equal partners; neither has priority over the other.
	assign clearReq = clearInputEdge | panelKeyEdge;

	// Power is seen two flops late, so ready lags a power change by three edges.
	assign powerPresent = pinNow[2];
	// The live port is read every cycle, so a new value applies at once.
	assign limit = clampSpeed(rotationSpeedThreshold);

	assign faultsAhead = mergeFaults(state.faults, faultDetect, stickyMask, clearReq);
	assign anyFaultAhead = |faultsAhead;
	assign modeAhead = stepMode(state.mode, anyFaultAhead);
	assign runningAhead = isRunning(modeAhead);
	assign speedAbove = aboveLimit(motorSpeed, limit);

	always_comb begin
		next_state = state;
		// Pin levels are remembered for the edge detectors of the next cycle.
		next_state.pinPrev = pinNow;
		next_state.faults = faultsAhead;
		next_state.mode = modeAhead;
		next_state.status = buildStatus(runningAhead, speedAbove, powerPresent);
	end

	// Reset puts every output OFF at once, without waiting for a clock edge,
	// so the power interlock opens on the next clock edge after control power is lost.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state.mode <= servo_status_pkg::ALM_RESET;
			state.faults <= '0;
			state.pinPrev <= '0;
			state.status <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Alarm, rotation and ready are flops of the status record and latchedFaults of the fault set, so no decode glitch reaches a pin.
	assign alarmOutput = state.status.alarmOutput;
	assign rotationDetectOutput = state.status.rotationDetectOutput;
	assign servoReady = state.status.servoReady;
	assign latchedFaults = state.faults;

endmodule

// file: core/servo_status_pkg.sv
package servo_status_pkg;

	localparam int SPEED_W = 12;
	localparam int FAULT_W = 8;

	localparam logic [SPEED_W-1:0] THRESHOLD_MAX     = 12'hbb8;
	localparam logic [SPEED_W-1:0] THRESHOLD_DEFAULT = 12'h014;

	// Fault classes set here survive the clear input and the panel key.
	localparam logic [FAULT_W-1:0] STICKY_MASK_DEFAULT = 8'hf0;

	localparam int SYNC_POS = 0;
	localparam int SYNC_W   = 3;

	typedef enum logic [2:0] {
		ALM_RESET   = 3'b001,
		ALM_RUN     = 3'b010,
		ALM_FAULTED = 3'b100
	} alarm_state_type;

	typedef struct packed {
		logic alarmOutput;
		logic rotationDetectOutput;
		logic servoReady;
	} status_type;

endpackage
